// ==== src/twrp_dev.sv ====
// Purpose: slave end of the two-wire port with pointer and write lock
// Assumes: temperature results arrive from a conversion engine
// Notes: lines pass two flip-flops and a glitch filter before use
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module twrp_dev #(
	parameter int TIMEOUT_CYCLES = twrp_pkg::TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [1:0] addr_sel,
	input wire twrp_pkg::twrp_temp_type temp_result,
	output logic [15:0] config_word,
	output logic [15:0] limit_word,
	output logic locked,
	output logic hs_mode,
	output logic soft_reset,
	twrp_if.dev bus
);
	import twrp_pkg::*;

	function automatic logic in_range(logic [7:0] p, logic [7:0] lo,
		logic [7:0] hi);
		in_range = (p >= lo) && (p <= hi);
	endfunction : in_range

	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] filt;
	logic [1:0][3:0] fcnt;
	logic scl_q;
	logic sda_q;
	logic [1:0] strap;
	logic strap_done;
	twrp_dstate_type state;
	twrp_kind_type kind;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] ptr;
	logic [7:0] msb_buf;
	logic rw;
	logic rd_low;
	logic mack;
	logic sda_drv;
	logic in_txn;
	logic [22:0] tcnt;
	logic [22:0] tcnt_sda;

	// filter length follows the speed mode
	wire [3:0] filt_len = hs_mode ? 4'(FILT_HS_CYC) : 4'(FILT_FS_CYC);
	wire scl_rise = filt[1] && !scl_q;
	wire scl_fall = !filt[1] && scl_q;
	wire start_det = scl_q && filt[1] && sda_q && !filt[0];
	wire stop_det = scl_q && filt[1] && !sda_q && filt[0];
	wire [6:0] my_addr = ADDR_BASE + 7'(strap);
	wire addr_hit = shreg[7:1] == my_addr;
	wire is_hs = shreg[7:3] == HS_CODE;
	wire blk = in_range(ptr, PTR_BLK_LO, PTR_BLK_HI);
	wire prot = locked && (ptr == PTR_CONFIG || ptr == PTR_LIMIT);
	wire [15:0] wr_word = {msb_buf, shreg};
	// each line has its own low-time count
	wire timeout = in_txn && (tcnt == 23'(TIMEOUT_CYCLES) ||
		tcnt_sda == 23'(TIMEOUT_CYCLES));
	wire [15:0] rd_word;
	wire [7:0] rd_byte = rd_low ? rd_word[7:0] : rd_word[15:8];
	wire ack_now;

	// mirrors share the low three pointer bits with the results
	assign rd_word = (in_range(ptr, PTR_TEMP_LO, PTR_TEMP_HI) || blk) ?
		temp_result[ptr[2:0]] :
		(ptr == PTR_CONFIG) ? config_word :
		(ptr == PTR_LIMIT) ? limit_word : 16'h0000;
	assign ack_now = (kind == K_ADDR) ? (addr_hit && !is_hs) :
		(kind == K_PTR) ? 1'b1 : !prot;

	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe = sda_drv;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1 <= 2'b11;
			sync2 <= 2'b11;
			filt <= 2'b11;
			fcnt <= '0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			sync1 <= {bus.scl, bus.sda};
			sync2 <= sync1;
			scl_q <= filt[1];
			sda_q <= filt[0];
			for (int i = 0; i < 2; i++) begin
				if (sync2[i] == filt[i]) begin
					fcnt[i] <= 4'h0;
				end else if (fcnt[i] >= filt_len) begin
					filt[i] <= sync2[i];
					fcnt[i] <= 4'h0;
				end else begin
					fcnt[i] <= fcnt[i] + 4'h1;
				end
			end
		end
	end

	// strap is caught once, after reset release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			strap <= 2'b00;
			strap_done <= 1'b0;
		end else if (ce && !strap_done) begin
			strap <= addr_sel;
			strap_done <= 1'b1;
		end
	end

	// bus-stuck watchdog inside a frame
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tcnt <= '0;
			tcnt_sda <= '0;
		end else if (ce) begin
			if (!in_txn || filt[1] || start_det) begin
				tcnt <= '0;
			end else if (!timeout) begin
				tcnt <= tcnt + 23'h1;
			end
			if (!in_txn || filt[0] || start_det) begin
				tcnt_sda <= '0;
			end else if (!timeout) begin
				tcnt_sda <= tcnt_sda + 23'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= D_IDLE;
			kind <= K_ADDR;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			msb_buf <= 8'h00;
			rw <= 1'b0;
			rd_low <= 1'b0;
			mack <= 1'b0;
			sda_drv <= 1'b0;
			in_txn <= 1'b0;
			hs_mode <= 1'b0;
			config_word <= CONFIG_POR;
			limit_word <= LIMIT_POR;
			locked <= 1'b1;
			soft_reset <= 1'b0;
		end else if (ce) begin
			soft_reset <= 1'b0;
			if (stop_det) begin
				state <= D_IDLE;
				sda_drv <= 1'b0;
				in_txn <= 1'b0;
				hs_mode <= 1'b0;
			end else if (start_det) begin
				state <= D_RX;
				kind <= K_ADDR;
				bit_cnt <= 4'h0;
				sda_drv <= 1'b0;
				in_txn <= 1'b1;
			end else if (timeout) begin
				state <= D_IDLE;
				sda_drv <= 1'b0;
				in_txn <= 1'b0;
				hs_mode <= 1'b0;
			end else begin
				unique case (state)
				D_IDLE: begin
				end
				D_RX: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						shreg <= {shreg[6:0], filt[0]};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						if (kind == K_ADDR && is_hs) begin
							hs_mode <= 1'b1;
							state <= D_IDLE;
						end else if (ack_now) begin
							sda_drv <= 1'b1;
							state <= D_RXACK;
							unique case (kind)
							K_ADDR: begin
								rw <= shreg[0];
								rd_low <= 1'b0;
							end
							K_PTR: begin
								ptr <= shreg;
							end
							K_MSB: begin
								msb_buf <= shreg;
							end
							K_LSB: begin
								// commit only here, at the second ack
								if (ptr == PTR_RST && wr_word[RST_BIT]) begin
									config_word <= CONFIG_POR;
									limit_word <= LIMIT_POR;
									locked <= 1'b1;
									ptr <= 8'h00;
									soft_reset <= 1'b1;
								end else if (ptr == PTR_CONFIG) begin
									config_word <= wr_word & CONFIG_MASK;
								end else if (ptr == PTR_LIMIT) begin
									limit_word <= wr_word & LIMIT_MASK;
								end else if (ptr == PTR_LOCK) begin
									if (wr_word == KEY_LOCK) begin
										locked <= 1'b1;
									end else if (wr_word == KEY_UNLOCK) begin
										locked <= 1'b0;
									end
								end
							end
							endcase
						end else begin
							state <= D_IDLE;
						end
					end
				end
				D_RXACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (kind == K_ADDR && rw) begin
							shreg <= rd_byte;
							sda_drv <= !rd_byte[7];
							state <= D_TX;
						end else begin
							sda_drv <= 1'b0;
							state <= D_RX;
							kind <= (kind == K_ADDR) ? K_PTR :
								(kind == K_MSB) ? K_LSB : K_MSB;
						end
					end
				end
				D_TX: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						sda_drv <= 1'b0;
						state <= D_TXACK;
					end else if (scl_fall) begin
						shreg <= {shreg[6:0], 1'b0};
						sda_drv <= !shreg[6];
					end
				end
				D_TXACK: begin
					if (scl_rise) begin
						mack <= !filt[0];
						rd_low <= !rd_low;
						if (rd_low && blk && ptr != PTR_BLK_HI) begin
							ptr <= ptr + 8'h01;
						end
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (mack) begin
							shreg <= rd_byte;
							sda_drv <= !rd_byte[7];
							state <= D_TX;
						end else begin
							state <= D_IDLE;
						end
					end
				end
				default: begin
					state <= D_IDLE;
				end
				endcase
			end
		end
	end
endmodule : twrp_dev

// ==== src/twrp_pkg.sv ====
// Purpose: shared constants and types of the two-wire register port
// Assumes: clk_sys at 250 MHz on both ends
// Notes: read the list below as the behaviour both ends keep
//
// Notes on behaviour
// - strap selects one of four slave addresses
// - first written byte loads the register pointer
// - block reads only at pointers 80h to 84h
// - 80h to temperature_block_read_end temperature results
// - reads use last written pointer, pointer kept
// - master sets pointer, then restarts to read
// - words go out high byte first
// - each read restarts at the high byte
// - master ends a read with nack or stop
// - master writes whole high/low byte pairs
// - word commits only at second data ack
// - block read auto-advances the pointer
// - early-ended block read leaves pointer advanced
// - line low 17.5 ms in frame resets port
// - on timeout release lines, await start
// - master keeps scl at 1 kHz or faster
// - master code 00001xxx enters high-speed, no ack
// - high-speed ends at stop, filters restored
// - reset bit 15 at 20h restores registers
// - lock keys at C4h protect config and limit
// - no ack for data to protected register
// - unlock key at C4h; locked after power-up
// - matching address byte is acknowledged
package twrp_pkg;
	localparam int CLK_NS = 4;
	localparam int TIMEOUT_US = 17500;
	localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_NS;
	localparam int FILT_FS_NS = 50;
	localparam int FILT_HS_NS = 10;
	localparam int FILT_FS_CYC = FILT_FS_NS / CLK_NS;
	localparam int FILT_HS_CYC = FILT_HS_NS / CLK_NS;
	localparam logic [6:0] ADDR_BASE = 7'h48;
	localparam logic [4:0] HS_CODE = 5'h01;
	localparam logic [7:0] HS_BYTE = 8'h08;
	localparam logic [7:0] PTR_TEMP_LO = 8'h00;
	localparam logic [7:0] PTR_TEMP_HI = 8'h04;
	localparam logic [7:0] PTR_RST = 8'h20;
	localparam logic [7:0] PTR_CONFIG = 8'h30;
	localparam logic [7:0] PTR_LIMIT = 8'h39;
	localparam logic [7:0] PTR_BLK_LO = 8'h80;
	localparam logic [7:0] PTR_BLK_HI = 8'h84;
	localparam logic [7:0] PTR_LOCK = 8'hc4;
	localparam int RST_BIT = 15;
	localparam logic [15:0] KEY_LOCK = 16'h5ca6;
	localparam logic [15:0] KEY_UNLOCK = 16'heb19;
	localparam logic [15:0] CONFIG_POR = 16'h0f9c;
	localparam logic [15:0] CONFIG_MASK = 16'h0ffc;
	localparam logic [15:0] LIMIT_POR = 16'h3e80;
	localparam logic [15:0] LIMIT_MASK = 16'hffc0;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_WDATA = 8'h04;
	localparam logic [7:0] A_RDATA = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_DIV = 8'h10;
	localparam int C_PTR = 8;
	localparam int C_READ = 16;
	localparam int C_WPTR = 17;
	localparam int C_CNT = 18;
	localparam int C_WDAT = 21;
	localparam int C_HS = 22;
	localparam logic [15:0] DIV_POR = 16'h0140;
	typedef logic [4:0][15:0] twrp_temp_type;
	typedef enum logic [2:0] {
		D_IDLE = 3'b000, D_RX = 3'b001, D_RXACK = 3'b010,
		D_TX = 3'b011, D_TXACK = 3'b100
	} twrp_dstate_type;
	typedef enum logic [1:0] {
		K_ADDR = 2'b00, K_PTR = 2'b01, K_MSB = 2'b10, K_LSB = 2'b11
	} twrp_kind_type;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000, H_S1 = 3'b001, H_LO = 3'b010, H_HI = 3'b011,
		H_R1 = 3'b100, H_R2 = 3'b101, H_P1 = 3'b110, H_P2 = 3'b111
	} twrp_hstate_type;
	typedef enum logic [2:0] {
		S_HS = 3'b000, S_AW = 3'b001, S_PTR = 3'b010, S_WMSB = 3'b011,
		S_WLSB = 3'b100, S_AR = 3'b101, S_RD = 3'b110
	} twrp_step_type;
endpackage : twrp_pkg

// ==== src/twrp_if.sv ====
// Purpose: open-drain two-wire link between bus master and device
// Assumes: an enabled output pulls its line low
// Notes: lines float high when nobody drives
`timescale 1ns/1ps
interface twrp_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
	modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
	modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
		output m_sda_o, output m_sda_oe);
endinterface : twrp_if

// ==== src/twrp_host.sv ====
// Purpose: bus master end, driven by software over APB
// Assumes: no clock stretching by the slave
// Notes: one word write or up to eight bytes read per command, eight at count 0
`timescale 1ns/1ps
module twrp_host (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	twrp_if.host link
);
	import twrp_pkg::*;

	logic [31:0] ctrl;
	logic [15:0] wdata;
	logic [31:0] rdata;
	logic [15:0] div;
	logic [15:0] dcnt;
	logic busy;
	logic nack;
	logic s1;
	logic s2;
	logic scl_lo;
	logic sda_lo;
	logic [3:0] bitn;
	logic [7:0] rx;
	logic [2:0] rd_cnt;
	twrp_hstate_type st;
	twrp_step_type step;

	wire [2:0] c_cnt = ctrl[C_CNT+:3];
	wire c_read = ctrl[C_READ];
	wire rd_first = c_read && !ctrl[C_WPTR];
	wire hit = paddr == A_CTRL || paddr == A_WDATA || paddr == A_RDATA ||
		paddr == A_STATUS || paddr == A_DIV;
	wire wr_acc = psel && penable && pwrite && hit;
	wire tick = busy && dcnt >= div;
	wire mid = busy && dcnt == {1'b0, div[15:1]};
	wire rd_last = rd_cnt == c_cnt - 3'h1;
	wire [7:0] tx_byte = (step == S_HS) ? HS_BYTE :
		(step == S_AW) ? {ctrl[6:0], 1'b0} :
		(step == S_PTR) ? ctrl[C_PTR+:8] :
		(step == S_WMSB) ? wdata[15:8] :
		(step == S_WLSB) ? wdata[7:0] :
		(step == S_AR) ? {ctrl[6:0], 1'b1} : 8'hff;
	// release on read data; ack low except after the last byte
	wire bitv = (bitn < 4'h8) ? tx_byte[3'(4'h7 - bitn)] :
		(step == S_RD) ? rd_last : 1'b1;
	wire nacked = s2 && step != S_RD && step != S_HS;
	wire go_stop = nacked || step == S_WLSB ||
		(step == S_RD && rd_last) ||
		(step == S_PTR && !ctrl[C_WDAT] && !c_read);
	wire go_rs = step == S_HS || (step == S_PTR && !ctrl[C_WDAT]);
	wire twrp_step_type nxt = (step == S_HS) ? (rd_first ? S_AR : S_AW) :
		(step == S_AW) ? S_PTR :
		(step == S_PTR) ? (ctrl[C_WDAT] ? S_WMSB : S_AR) :
		(step == S_WMSB) ? S_WLSB : S_RD;
	wire [31:0] rd_mux = (paddr == A_CTRL) ? ctrl :
		(paddr == A_WDATA) ? {16'h0000, wdata} :
		(paddr == A_RDATA) ? rdata :
		(paddr == A_STATUS) ? {30'h0, nack, busy} :
		(paddr == A_DIV) ? {16'h0000, div} : 32'h0;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign link.m_scl_o = 1'b0;
	assign link.m_sda_o = 1'b0;
	assign link.m_scl_oe = scl_lo;
	assign link.m_sda_oe = sda_lo;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0;
			s1 <= 1'b1;
			s2 <= 1'b1;
			dcnt <= 16'h0;
		end else if (ce) begin
			if (psel && !penable) begin
				prdata <= rd_mux;
			end
			s1 <= link.sda;
			s2 <= s1;
			dcnt <= (!busy || tick) ? 16'h0 : dcnt + 16'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl <= 32'h0;
			wdata <= 16'h0;
			rdata <= 32'h0;
			div <= DIV_POR;
			busy <= 1'b0;
			nack <= 1'b0;
			scl_lo <= 1'b0;
			sda_lo <= 1'b0;
			bitn <= 4'h0;
			rx <= 8'h0;
			rd_cnt <= 3'h0;
			st <= H_IDLE;
			step <= S_AW;
		end else if (ce) begin
			if (wr_acc && paddr == A_CTRL && !busy) begin
				ctrl <= pwdata;
				busy <= 1'b1;
				nack <= 1'b0;
				rd_cnt <= 3'h0;
			end
			if (wr_acc && paddr == A_WDATA) begin
				wdata <= pwdata[15:0];
			end
			if (wr_acc && paddr == A_DIV && !busy) begin
				div <= pwdata[15:0];
			end
			unique case (st)
			H_IDLE: begin
				if (tick) begin
					step <= ctrl[C_HS] ? S_HS :
						(rd_first ? S_AR : S_AW);
					sda_lo <= 1'b1;
					st <= H_S1;
				end
			end
			H_S1: begin
				if (tick) begin
					scl_lo <= 1'b1;
					bitn <= 4'h0;
					st <= H_LO;
				end
			end
			H_LO: begin
				if (tick) begin
					scl_lo <= 1'b0;
					st <= H_HI;
				end else if (mid) begin
					sda_lo <= !bitv;
				end
			end
			H_HI: begin
				if (tick) begin
					scl_lo <= 1'b1;
					if (bitn != 4'h8) begin
						rx <= {rx[6:0], s2};
						bitn <= bitn + 4'h1;
						st <= H_LO;
					end else begin
						bitn <= 4'h0;
						if (step == S_RD) begin
							rdata <= {rdata[23:0], rx};
							rd_cnt <= rd_cnt + 3'h1;
						end
						if (nacked) begin
							nack <= 1'b1;
						end
						step <= nxt;
						st <= go_stop ? H_P1 : (go_rs ? H_R1 : H_LO);
					end
				end
			end
			H_R1: begin
				if (tick) begin
					scl_lo <= 1'b0;
					st <= H_R2;
				end else if (mid) begin
					sda_lo <= 1'b0;
				end
			end
			H_R2: begin
				if (tick) begin
					sda_lo <= 1'b1;
					st <= H_S1;
				end
			end
			H_P1: begin
				if (tick) begin
					scl_lo <= 1'b0;
					st <= H_P2;
				end else if (mid) begin
					sda_lo <= 1'b1;
				end
			end
			H_P2: begin
				if (tick) begin
					sda_lo <= 1'b0;
					busy <= 1'b0;
					st <= H_IDLE;
				end
			end
			endcase
		end
	end
endmodule : twrp_host

// ==== tb/twrp_sva.sv ====
// Purpose: wire-level checks on the two-wire link
// Assumes: scl low phases last well over the device filter delay
// Notes: byte framing is rebuilt from scl rises after each start
`timescale 1ns/1ps
module twrp_sva #(
	parameter int TIMEOUT_CYCLES = 2000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] addr_sel,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	import twrp_pkg::*;
	logic scl_q, sda_q, stale, wr_hit, rd_hit;
	logic [3:0] bit_cnt;
	logic [1:0] byte_idx;
	logic [7:0] shreg;
	logic [31:0] low_cnt;
	wire rise = scl && !scl_q;
	wire start = scl && scl_q && sda_q && !sda;
	wire ack_slot = rise && bit_cnt == 4'h8;
	wire first = ack_slot && byte_idx == 2'h0;
	wire addr_hit = shreg[7:1] == (ADDR_BASE | {5'h0, addr_sel});
	wire hs_code = shreg[7:3] == HS_CODE;
	wire [3:0] next_bit_cnt = (start || ack_slot) ? 4'h0 :
		bit_cnt + {3'h0, rise};
	wire [1:0] next_byte_idx = start ? 2'h0 :
		byte_idx + {1'b0, ack_slot && byte_idx != 2'h3};
	wire [7:0] next_shreg = (rise && !ack_slot) ? {shreg[6:0], sda} : shreg;
	// long scl low inside a frame: port may have given up
	wire next_stale = !start && (stale || low_cnt >= TIMEOUT_CYCLES);
	wire next_wr_hit = !start && (first ? addr_hit && !shreg[0] : wr_hit);
	wire next_rd_hit = !start && (first ? addr_hit && shreg[0] : rd_hit);
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			{scl_q, sda_q, stale, wr_hit, rd_hit} <= 5'b11000;
			{bit_cnt, byte_idx, shreg} <= 14'h0;
			low_cnt <= 32'h0;
		end else begin
			{scl_q, sda_q, stale, wr_hit, rd_hit} <= {scl, sda, next_stale,
				next_wr_hit, next_rd_hit};
			{bit_cnt, byte_idx, shreg} <= {next_bit_cnt, next_byte_idx, next_shreg};
			low_cnt <= scl ? 32'h0 : low_cnt + 32'h1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	a_addr_ack: assert property (
		first && addr_hit && !stale |-> !sda)
		else $error("own address not acknowledged");
	a_hs_nack: assert property (
		first && hs_code |-> sda)
		else $error("master code acknowledged");
	a_foreign_nack: assert property (
		first && !addr_hit && !hs_code |-> sda)
		else $error("foreign address acknowledged");
	a_ptr_ack: assert property (
		ack_slot && byte_idx == 2'h1 && wr_hit && !stale |-> !sda)
		else $error("pointer byte not acknowledged");
	a_sda_steady: assert property (
		$changed(d_sda_oe) |-> !scl)
		else $error("device moved sda while scl high");
	a_rd_ack_free: assert property (
		ack_slot && rd_hit && byte_idx != 2'h0 |-> !d_sda_oe)
		else $error("device drove sda in master ack slot");
	a_reset_idle: assert property (
		$fell(reset) |-> !d_sda_oe && !m_sda_oe && !m_scl_oe)
		else $error("line held after reset");
	a_timeout_free: assert property (
		$rose(stale) |-> ##[0:60] !d_sda_oe)
		else $error("sda held after bus timeout");
endmodule : twrp_sva

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench, host and device joined on one link
// Assumes: device timeout shortened to TO_CYC cycles
// Notes: no long zero runs on sda in normal traffic
`timescale 1ns/1ps
module tb_top;
	import twrp_pkg::*;
	localparam int TO_CYC = 1000;
	localparam logic [6:0] DEV = 7'h48;
	logic clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr;
	logic locked, hs_mode, soft_reset, nk, e;
	logic [1:0] addr_sel;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] config_word, limit_word;
	twrp_temp_type temp;
	int n_fail = 0;
	int samples_checked = 0;
	int n_pulse = 0;
	int n_hs = 0;
	twrp_if twrp_if_i ();
	twrp_dev #(.TIMEOUT_CYCLES(TO_CYC)) twrp_dev_i (.clk_sys(clk_sys),
		.reset(reset), .ce(ce), .addr_sel(addr_sel), .temp_result(temp),
		.config_word(config_word), .limit_word(limit_word), .locked(locked),
		.hs_mode(hs_mode), .soft_reset(soft_reset), .bus(twrp_if_i.dev));
	twrp_host twrp_host_i (.clk_sys(clk_sys), .reset(reset), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(twrp_if_i.host));
	twrp_sva #(.TIMEOUT_CYCLES(TO_CYC)) twrp_sva_i (.clk_sys(clk_sys),
		.reset(reset), .addr_sel(addr_sel), .m_scl_o(twrp_if_i.m_scl_o),
		.m_scl_oe(twrp_if_i.m_scl_oe), .m_sda_o(twrp_if_i.m_sda_o),
		.m_sda_oe(twrp_if_i.m_sda_oe), .d_sda_o(twrp_if_i.d_sda_o),
		.d_sda_oe(twrp_if_i.d_sda_oe), .scl(twrp_if_i.scl),
		.sda(twrp_if_i.sda));
	always @(posedge clk_sys) begin
		if (soft_reset === 1'b1)
			n_pulse <= n_pulse + 1;
		if (hs_mode === 1'b1)
			n_hs <= n_hs + 1;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	// one link command, then wait until the host is idle again
	task automatic xfer(input logic [6:0] a, input logic [7:0] p,
		input logic [6:0] f);
		apb(1'b1, A_CTRL, {9'h0, f, p, 1'b0, a});
		q = 32'h1;
		while (q[0] !== 1'b0)
			apb(1'b0, A_STATUS, 32'h0);
		nk = q[1];
		apb(1'b0, A_RDATA, 32'h0);
	endtask : xfer
	task automatic wword(input logic [7:0] p, input logic [15:0] d);
		apb(1'b1, A_WDATA, {16'h0, d});
		xfer(DEV, p, 7'h22);
	endtask : wword
	function automatic logic [6:0] rd(input logic [2:0] n, input logic wp);
		return {2'b00, n, wp, 1'b1};
	endfunction : rd
	task automatic do_reset(input logic [1:0] s);
		reset <= 1'b1;
		addr_sel <= s;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		apb(1'b1, A_DIV, 32'h28);
	endtask : do_reset
	task automatic s_strap;
		for (int k = 3; k >= 0; k--) begin
			do_reset(2'(k));
			xfer(DEV | 7'(k), 8'h82, 7'h02);
			chk(32'(nk), 32'h0);
			xfer(DEV | 7'(k ^ 1), 8'h82, 7'h02);
			chk(32'(nk), 32'h1);
		end
		chk(32'(locked), 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
	endtask : s_strap
	task automatic s_read;
		xfer(DEV, 8'h02, rd(3'd2, 1'b1));
		chk(32'(q[15:0]), 32'(temp[2]));
		xfer(DEV, 8'h00, rd(3'd1, 1'b0));
		chk(32'(q[7:0]), 32'(temp[2][15:8]));
		xfer(DEV, 8'h00, rd(3'd2, 1'b0));
		chk(32'(q[15:0]), 32'(temp[2]));
		xfer(DEV, 8'h00, rd(3'd4, 1'b0));
		chk(q, {temp[2], temp[2]});
		xfer(DEV, PTR_BLK_LO, rd(3'd7, 1'b1));
		chk(q, {temp[1][7:0], temp[2], temp[3][15:8]});
		xfer(DEV, 8'h00, rd(3'd2, 1'b0));
		chk(32'(q[15:0]), 32'(temp[3]));
		xfer(DEV, PTR_BLK_HI, rd(3'd2, 1'b1));
		chk(32'(q[15:0]), 32'(temp[4]));
	endtask : s_read
	task automatic s_lock;
		wword(PTR_CONFIG, 16'h0a5c);
		chk(32'(nk), 32'h1);
		chk(32'(config_word), 32'(CONFIG_POR));
		wword(PTR_LOCK, KEY_UNLOCK);
		chk(32'(locked), 32'h0);
		wword(PTR_CONFIG, 16'h0a5c);
		chk(32'(config_word), 32'(16'h0a5c & CONFIG_MASK));
		wword(PTR_LIMIT, 16'h5a5a);
		xfer(DEV, PTR_LIMIT, 7'h02);
		chk(32'(limit_word), 32'(16'h5a5a & LIMIT_MASK));
		wword(PTR_LOCK, KEY_LOCK);
		chk(32'(locked), 32'h1);
		wword(PTR_LIMIT, 16'h1234);
		chk(32'(limit_word), 32'(16'h5a5a & LIMIT_MASK));
		xfer(DEV, 8'h02, rd(3'd2, 1'b1));
		chk(32'(q[15:0]), 32'(temp[2]));
		wword(PTR_LOCK, KEY_UNLOCK);
		chk(32'(locked), 32'h0);
	endtask : s_lock
	task automatic s_reset_hs;
		int p0;
		int h0;
		p0 = n_pulse;
		wword(PTR_RST, 16'h8421);
		chk(32'(n_pulse - p0), 32'h1);
		chk({config_word, limit_word}, {CONFIG_POR, LIMIT_POR});
		chk(32'(locked), 32'h1);
		h0 = n_hs;
		xfer(DEV, 8'h00, 7'h40 | rd(3'd2, 1'b0));
		chk(32'(q[15:0]), 32'(temp[0]));
		chk(32'(n_hs != h0), 32'h1);
		// stop reaches the device some cycles after busy drops
		repeat (20) @(posedge clk_sys);
		chk(32'(hs_mode), 32'h0);
	endtask : s_reset_hs
	// scl low phase longer than the device timeout
	task automatic s_timeout;
		apb(1'b1, A_DIV, 32'h424);
		xfer(DEV, 8'h82, 7'h02);
		chk(32'(nk), 32'h1);
		apb(1'b1, A_DIV, 32'h28);
		xfer(DEV, 8'h82, 7'h02);
		chk(32'(nk), 32'h0);
	endtask : s_timeout
	task automatic end_sim;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (110000) @(posedge clk_sys);
		n_fail++;
		end_sim();
	end
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		addr_sel = 2'h0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		temp = {16'h1e78, 16'h690f, 16'h781e, 16'h4b2d, 16'h5a3c};
		s_strap();
		s_read();
		s_lock();
		s_reset_hs();
		s_timeout();
		end_sim();
	end
endmodule : tb_top
